// file: core/gam_pkg.sv
// package of constants and types for the general addressing mode decoder
package gam_pkg;
  localparam logic [4:0] GAM_REG_LO     = 5'h00;
  localparam logic [4:0] GAM_REG_HI     = 5'h07;
  localparam logic [4:0] GAM_RREL_LO    = 5'h08;
  localparam logic [4:0] GAM_RREL_HI    = 5'h0f;
  localparam logic [4:0] GAM_MREL_FRAME = 5'h10;
  localparam logic [4:0] GAM_MREL_STACK = 5'h11;
  localparam logic [4:0] GAM_MREL_SBASE = 5'h12;
  localparam logic [4:0] GAM_RESERVED   = 5'h13;
  localparam logic [4:0] GAM_IMMEDIATE  = 5'h14;
  localparam logic [4:0] GAM_ABSOLUTE   = 5'h15;
  localparam logic [4:0] GAM_LINK_TABLE = 5'h16;
  localparam logic [4:0] GAM_TOP_STACK  = 5'h17;
  localparam logic [4:0] GAM_MSP_FRAME  = 5'h18;
  localparam logic [4:0] GAM_MSP_STACK  = 5'h19;
  localparam logic [4:0] GAM_MSP_SBASE  = 5'h1a;
  localparam logic [4:0] GAM_MSP_PC     = 5'h1b;
  localparam logic [4:0] GAM_INDEX_LO   = 5'h1c;
  // index byte layout: base mode in [7:3], index register in [2:0]
  localparam int GAM_IDX_MODE_POS = 3;
  localparam int GAM_IDX_REG_POS  = 0;
  localparam int GAM_RST_CYCLES   = 1;

  // effective address computation class, one-hot
  typedef enum logic [9:0] {
    GAM_C_NONE     = 10'h001,
    GAM_C_REG      = 10'h002,
    GAM_C_REG_REL  = 10'h004,
    GAM_C_MEM_REL  = 10'h008,
    GAM_C_IMM      = 10'h010,
    GAM_C_ABS      = 10'h020,
    GAM_C_LINK     = 10'h040,
    GAM_C_STACKTOP = 10'h080,
    GAM_C_MEM_SPC  = 10'h100,
    GAM_C_ILLEGAL  = 10'h200
  } gam_class_type;

  // base register selection for the address unit
  typedef enum logic [5:0] {
    GAM_B_NONE  = 6'h01,
    GAM_B_GPR   = 6'h02,
    GAM_B_FRAME = 6'h04,
    GAM_B_STACK = 6'h08,
    GAM_B_SBASE = 6'h10,
    GAM_B_PC    = 6'h20
  } gam_base_type;
endpackage

// file: core/gam_decoder.sv
// general addressing mode decoder, one cycle of latency
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - codes 0 to 7 pick register 0..7 (or floating) directly, no address
// - codes 16..18 fetch pointer at disp1 plus frame/stack/static base, add disp2
// - code 19 is reserved and decodes as illegal
// - code 20 takes operand from instruction queue, no address
// - code 22 reads pointer from link table entry disp1, adds disp2
// - code 23 uses status-selected stack pointer with automatic adjust
// - codes 24..27 add displacement to frame, stack, static base or pc
// - codes 28..31 add index register scaled by 1, 2, 4 or 8
// - scaled modes take base mode and index register from the index byte
// - top of stack pushes on write and pops on read
// - scaled index not allowed on immediate or another scaled index base
// - immediate mode refused for a written operand
module gam_decoder (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       dec_valid,
  input  wire logic [4:0] mode_field,
  input  wire logic [7:0] index_byte,
  input  wire logic       operand_write,
  input  wire logic       float_op,
  input  wire logic       user_stack_sel,
  output logic            out_valid,
  output logic [9:0]      ea_class,
  output logic [5:0]      ea_base,
  output logic [2:0]      reg_num,
  output logic            reg_is_float,
  output logic            use_disp1,
  output logic            use_disp2,
  output logic            mem_indirect,
  output logic            indexed,
  output logic [3:0]      index_scale,
  output logic [2:0]      index_reg,
  output logic            stack_user,
  output logic            stack_push,
  output logic            stack_pop,
  output logic            mode_illegal
);

  ////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic       valid;
    logic [9:0] cls;
    logic [5:0] base;
    logic [2:0] rnum;
    logic       rflt;
    logic       d1;
    logic       d2;
    logic       ind;
    logic       idx;
    logic [3:0] scale;
    logic [2:0] ireg;
    logic       suser;
    logic       push;
    logic       pop;
    logic       ill;
  } gam_state_type;

  gam_state_type st_r;
  gam_state_type st_nxt;
  logic [4:0]    base_mode;
  logic          is_scaled;

  ////////////////////////////////////////////////////////////////////////
  // decode of mode field and index byte
  always_comb begin
    is_scaled = mode_field >= gam_pkg::GAM_INDEX_LO;
    // scaled modes take their base mode from the index byte
    base_mode = is_scaled ? index_byte[gam_pkg::GAM_IDX_MODE_POS +: 5] : mode_field;
    st_nxt = '0;
    st_nxt.valid = dec_valid;
    st_nxt.cls = gam_pkg::GAM_C_NONE;
    st_nxt.base = gam_pkg::GAM_B_NONE;
    if (dec_valid) begin
      if (is_scaled) begin
        st_nxt.idx = 1'b1;
        st_nxt.scale = 4'h1 << mode_field[1:0];
        st_nxt.ireg = index_byte[gam_pkg::GAM_IDX_REG_POS +: 3];
      end
      if (base_mode <= gam_pkg::GAM_REG_HI) begin
        st_nxt.cls = gam_pkg::GAM_C_REG;
        st_nxt.rnum = base_mode[2:0];
        st_nxt.rflt = float_op;
      end else if (base_mode <= gam_pkg::GAM_RREL_HI) begin
        st_nxt.cls = gam_pkg::GAM_C_REG_REL;
        st_nxt.base = gam_pkg::GAM_B_GPR;
        st_nxt.rnum = base_mode[2:0];
        st_nxt.d1 = 1'b1;
      end else if (base_mode <= gam_pkg::GAM_MREL_SBASE) begin
        st_nxt.cls = gam_pkg::GAM_C_MEM_REL;
        st_nxt.d1 = 1'b1;
        st_nxt.d2 = 1'b1;
        st_nxt.ind = 1'b1;
        st_nxt.suser = user_stack_sel;
        st_nxt.base = (base_mode == gam_pkg::GAM_MREL_FRAME) ? gam_pkg::GAM_B_FRAME :
                      (base_mode == gam_pkg::GAM_MREL_STACK) ? gam_pkg::GAM_B_STACK :
                      gam_pkg::GAM_B_SBASE;
      end else if (base_mode == gam_pkg::GAM_RESERVED) begin
        st_nxt.cls = gam_pkg::GAM_C_ILLEGAL;
        st_nxt.ill = 1'b1;
      end else if (base_mode == gam_pkg::GAM_IMMEDIATE) begin
        st_nxt.cls = gam_pkg::GAM_C_IMM;
        // immediate refused as destination or as scaled base
        st_nxt.ill = operand_write | is_scaled;
      end else if (base_mode == gam_pkg::GAM_ABSOLUTE) begin
        st_nxt.cls = gam_pkg::GAM_C_ABS;
        st_nxt.d1 = 1'b1;
      end else if (base_mode == gam_pkg::GAM_LINK_TABLE) begin
        st_nxt.cls = gam_pkg::GAM_C_LINK;
        st_nxt.d1 = 1'b1;
        st_nxt.d2 = 1'b1;
        st_nxt.ind = 1'b1;
      end else if (base_mode == gam_pkg::GAM_TOP_STACK) begin
        st_nxt.cls = gam_pkg::GAM_C_STACKTOP;
        st_nxt.base = gam_pkg::GAM_B_STACK;
        st_nxt.suser = user_stack_sel;
        st_nxt.push = operand_write;
        st_nxt.pop = ~operand_write;
      end else if (base_mode <= gam_pkg::GAM_MSP_PC) begin
        st_nxt.cls = gam_pkg::GAM_C_MEM_SPC;
        st_nxt.d1 = 1'b1;
        st_nxt.suser = user_stack_sel;
        unique case (base_mode[1:0])
          2'h0: st_nxt.base = gam_pkg::GAM_B_FRAME;
          2'h1: st_nxt.base = gam_pkg::GAM_B_STACK;
          2'h2: st_nxt.base = gam_pkg::GAM_B_SBASE;
          2'h3: st_nxt.base = gam_pkg::GAM_B_PC;
        endcase
      end else begin
        // a scaled index as base of a scaled index
        st_nxt.cls = gam_pkg::GAM_C_ILLEGAL;
        st_nxt.ill = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r <= '{cls: gam_pkg::GAM_C_NONE, base: gam_pkg::GAM_B_NONE, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  assign out_valid    = st_r.valid;
  assign ea_class     = st_r.cls;
  assign ea_base      = st_r.base;
  assign reg_num      = st_r.rnum;
  assign reg_is_float = st_r.rflt;
  assign use_disp1    = st_r.d1;
  assign use_disp2    = st_r.d2;
  assign mem_indirect = st_r.ind;
  assign indexed      = st_r.idx;
  assign index_scale  = st_r.scale;
  assign index_reg    = st_r.ireg;
  assign stack_user   = st_r.suser;
  assign stack_push   = st_r.push;
  assign stack_pop    = st_r.pop;
  assign mode_illegal = st_r.ill;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  property p_reg_direct;
    @(posedge sys_clk) disable iff (rst)
      dec_valid && mode_field <= 5'h07 |=> ea_class == gam_pkg::GAM_C_REG && reg_num == $past(mode_field[2:0]);
  endproperty
  a_reg_direct: assert property (p_reg_direct) else $error("register mode misdecoded");

  property p_reg_rel;
    @(posedge sys_clk) disable iff (rst)
      dec_valid && mode_field[4:3] == 2'h1 |=> ea_base == gam_pkg::GAM_B_GPR && use_disp1 && !use_disp2;
  endproperty
  a_reg_rel: assert property (p_reg_rel) else $error("register relative misdecoded");

  property p_mem_rel;
    @(posedge sys_clk) disable iff (rst)
      dec_valid && mode_field == 5'h11 |=> mem_indirect && use_disp2 && ea_base == gam_pkg::GAM_B_STACK;
  endproperty
  a_mem_rel: assert property (p_mem_rel) else $error("memory relative misdecoded");

  property p_reserved;
    @(posedge sys_clk) disable iff (rst)
      dec_valid && mode_field == 5'h13 |=> mode_illegal && out_valid;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved code accepted");

  property p_imm_write;
    @(posedge sys_clk) disable iff (rst)
      dec_valid && mode_field == 5'h14 |=> mode_illegal == $past(operand_write) && ea_class == gam_pkg::GAM_C_IMM;
  endproperty
  a_imm_write: assert property (p_imm_write) else $error("immediate write check wrong");

  property p_abs;
    @(posedge sys_clk) disable iff (rst)
      dec_valid && mode_field == 5'h15 |=> ea_base == gam_pkg::GAM_B_NONE && use_disp1 && !mem_indirect;
  endproperty
  a_abs: assert property (p_abs) else $error("absolute mode misdecoded");

  property p_tos;
    @(posedge sys_clk) disable iff (rst)
      dec_valid && mode_field == 5'h17 |=> stack_push == $past(operand_write) && stack_pop != stack_push
        && stack_user == $past(user_stack_sel);
  endproperty
  a_tos: assert property (p_tos) else $error("top of stack adjust wrong");

  property p_scale;
    @(posedge sys_clk) disable iff (rst)
      dec_valid && mode_field >= 5'h1c |=> indexed && index_scale == (4'h1 << $past(mode_field[1:0]))
        && index_reg == $past(index_byte[2:0]);
  endproperty
  a_scale: assert property (p_scale) else $error("scaled index wrong");

  property p_nested;
    @(posedge sys_clk) disable iff (rst)
      dec_valid && mode_field >= 5'h1c && index_byte[7:3] >= 5'h1c |=> mode_illegal;
  endproperty
  a_nested: assert property (p_nested) else $error("nested index accepted");

endmodule
`default_nettype wire

// file: tb/tb_top.sv
// self-checking testbench for the general addressing mode decoder
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic       sys_clk        = 1'b0;
  logic       rst            = 1'b1;
  logic       dec_valid      = 1'b0;
  logic [4:0] mode_field     = 5'h00;
  logic [7:0] index_byte     = 8'h00;
  logic       operand_write  = 1'b0;
  logic       float_op       = 1'b0;
  logic       user_stack_sel = 1'b0;
  logic       out_valid, reg_is_float, use_disp1, use_disp2, mem_indirect, indexed;
  logic       stack_user, stack_push, stack_pop, mode_illegal;
  logic [9:0] ea_class;
  logic [5:0] ea_base;
  logic [2:0] reg_num, index_reg;
  logic [3:0] index_scale;
  int         miscompares = 0;
  int         checks      = 0;
  int         cyc         = 0;
  localparam logic [5:0] MSP_BASE [4] = '{gam_pkg::GAM_B_FRAME, gam_pkg::GAM_B_STACK,
                                         gam_pkg::GAM_B_SBASE, gam_pkg::GAM_B_PC};

  gam_decoder u_dut (.sys_clk(sys_clk), .rst(rst), .dec_valid(dec_valid), .mode_field(mode_field),
    .index_byte(index_byte), .operand_write(operand_write), .float_op(float_op),
    .user_stack_sel(user_stack_sel), .out_valid(out_valid), .ea_class(ea_class), .ea_base(ea_base),
    .reg_num(reg_num), .reg_is_float(reg_is_float), .use_disp1(use_disp1), .use_disp2(use_disp2),
    .mem_indirect(mem_indirect), .indexed(indexed), .index_scale(index_scale), .index_reg(index_reg),
    .stack_user(stack_user), .stack_push(stack_push), .stack_pop(stack_pop), .mode_illegal(mode_illegal));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    checks = checks + 1;
    if (g !== e) begin
      miscompares = miscompares + 1;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // present one request at the falling edge, return once its answer stands
  task automatic req(input logic [4:0] m, input logic [7:0] ib, input logic wr, input logic fl, input logic us);
    mode_field = m;
    index_byte = ib;
    operand_write = wr;
    float_op = fl;
    user_stack_sel = us;
    dec_valid = 1'b1;
    @(negedge sys_clk);
    chk("out_valid", 10'h001, {9'h000, out_valid});
  endtask

  task automatic print_verdict();
    if (miscompares == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_direct();
    for (int i = 0; i < 16; i++) begin
      req(5'(i), 8'h00, 1'b0, i[0], 1'b0);
      chk("ea_class", (i < 8) ? gam_pkg::GAM_C_REG : gam_pkg::GAM_C_REG_REL, ea_class);
      chk("reg_num", 10'(i[2:0]), 10'(reg_num));
      chk("use_disp1", 10'(i >= 8), 10'(use_disp1));
      chk("mem_indirect", 10'h000, 10'(mem_indirect));
      if (i < 8) chk("reg_is_float", 10'(i[0]), 10'(reg_is_float));
      else chk("ea_base", 10'(gam_pkg::GAM_B_GPR), 10'(ea_base));
    end
  endtask

  task automatic t_pointer();
    for (int i = 0; i < 3; i++) begin
      req(5'(16 + i), 8'h00, 1'b0, 1'b0, 1'b1);
      chk("ea_class", gam_pkg::GAM_C_MEM_REL, ea_class);
      chk("ea_base", 10'(MSP_BASE[i]), 10'(ea_base));
      chk("disp12_ind", 10'h007, {7'h00, use_disp1, use_disp2, mem_indirect});
      chk("stack_user", 10'h001, 10'(stack_user));
    end
    req(gam_pkg::GAM_LINK_TABLE, 8'h00, 1'b1, 1'b0, 1'b0);
    chk("ea_class", gam_pkg::GAM_C_LINK, ea_class);
    chk("disp12_ind", 10'h007, {7'h00, use_disp1, use_disp2, mem_indirect});
    req(gam_pkg::GAM_ABSOLUTE, 8'h00, 1'b0, 1'b0, 1'b0);
    chk("ea_class", gam_pkg::GAM_C_ABS, ea_class);
    chk("ea_base", 10'(gam_pkg::GAM_B_NONE), 10'(ea_base));
    chk("disp1_ind", 10'h002, {8'h00, use_disp1, mem_indirect});
  endtask

  task automatic t_special();
    req(gam_pkg::GAM_RESERVED, 8'h00, 1'b0, 1'b0, 1'b0);
    chk("ea_class", gam_pkg::GAM_C_ILLEGAL, ea_class);
    chk("mode_illegal", 10'h001, 10'(mode_illegal));
    for (int w = 0; w < 2; w++) begin
      req(gam_pkg::GAM_IMMEDIATE, 8'h00, w[0], 1'b0, 1'b0);
      chk("ea_class", gam_pkg::GAM_C_IMM, ea_class);
      chk("mem_indirect", 10'h000, 10'(mem_indirect));
      chk("mode_illegal", 10'(w), 10'(mode_illegal));
      req(gam_pkg::GAM_TOP_STACK, 8'h00, w[0], 1'b0, ~w[0]);
      chk("ea_class", gam_pkg::GAM_C_STACKTOP, ea_class);
      chk("ea_base", 10'(gam_pkg::GAM_B_STACK), 10'(ea_base));
      chk("stack_user", {9'h000, ~w[0]}, 10'(stack_user));
      chk("push_pop", (w == 1) ? 10'h002 : 10'h001, {8'h00, stack_push, stack_pop});
    end
  endtask

  task automatic t_space_index();
    for (int s = 0; s < 4; s++) begin
      req(5'(24 + s), 8'h00, 1'b0, 1'b0, 1'b0);
      chk("ea_class", gam_pkg::GAM_C_MEM_SPC, ea_class);
      chk("ea_base", 10'(MSP_BASE[s]), 10'(ea_base));
      req(5'(28 + s), {5'h18 + 5'(s), 3'(s + 4)}, 1'b0, 1'b0, 1'b0);
      chk("ea_base", 10'(MSP_BASE[s]), 10'(ea_base));
      chk("index_scale", 10'(4'h1 << s), 10'(index_scale));
      chk("index_reg", 10'(s + 4), 10'(index_reg));
      chk("indexed", 10'h001, 10'(indexed));
    end
    req(5'h1d, 8'h56, 1'b0, 1'b0, 1'b0);
    chk("ea_class", gam_pkg::GAM_C_REG_REL, ea_class);
    chk("reg_num", 10'h002, 10'(reg_num));
    chk("mode_illegal", 10'h000, 10'(mode_illegal));
    req(5'h1c, 8'ha1, 1'b0, 1'b0, 1'b0);
    chk("ea_class", gam_pkg::GAM_C_IMM, ea_class);
    chk("mode_illegal", 10'h001, 10'(mode_illegal));
    req(5'h1f, 8'he1, 1'b0, 1'b0, 1'b0);
    chk("ea_class", gam_pkg::GAM_C_ILLEGAL, ea_class);
    dec_valid = 1'b0;
    @(negedge sys_clk);
    chk("idle_valid", 10'h000, 10'(out_valid));
    chk("idle_class", gam_pkg::GAM_C_NONE, ea_class);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(negedge sys_clk);
    chk("rst_class", gam_pkg::GAM_C_NONE, ea_class);
    rst = 1'b0;
    t_direct();
    t_pointer();
    t_special();
    t_space_index();
    print_verdict();
  end
endmodule
`default_nettype wire
